// File: inc/engine_regs_consts.svh
// Purpose: offsets, field positions and reset values of the engine register bank
// Assumes: byte-wide register port, offsets are byte addresses in the engine space
// Notes:   included by the design modules and the testbench
`ifndef ENGINE_REGS_CONSTS_SVH
`define ENGINE_REGS_CONSTS_SVH
// ==================================================
// register offsets
`define OFF_AUX_STATUS   8'h09
`define OFF_LEN_A        8'h0c
`define OFF_LEN_B        8'h0d
`define OFF_CONTROL      8'h11
`define OFF_BANK_SELECT  8'h12
`define OFF_BASE         8'h14
`define OFF_WIDTH        8'h18
`define OFF_HEIGHT       8'h1a
`define OFF_FORMAT       8'h1c
// ==================================================
// control and field bit positions
`define BIT_BUSY         7
`define BIT_TERMINATE    5
`define BIT_SUSPENDED    4
`define BIT_SUSPEND      3
`define BIT_SAVE_SEL     1
`define BIT_ORDER        3
`define FMT_SIZE_MSB     2
`define FMT_ORDER_MASK   8'h08
`define FMT_VALID_MASK   8'h0f
`define BANK_MASK_MAP    2'h0
// ==================================================
// reset values and state lengths
`define RST_BYTE         8'h00
`define RST_WORD         32'h0000_0000
`define RST_HALF         16'h0000
`define LEN_A_WORDS      8'h10
`define LEN_B_WORDS      8'h10
`define TERM_CYCLES      4'h3
`define SIZE_16          3'h4
`endif

// File: inc/engine_regs_pkg.sv
// Purpose: shared types for the engine register bank
// Assumes: constants come from the consts header
// Notes:   types only
package engine_regs_pkg;
  // ==================================================
  // engine run states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0001,
    ST_RUN       = 4'b0010,
    ST_SUSPENDED = 4'b0100,
    ST_TERMINATE = 4'b1000
  } engine_state_type;
  // pixel size codes
  typedef enum logic [2:0] {
    PS_1 = 3'h0,
    PS_2 = 3'h1,
    PS_4 = 3'h2,
    PS_8 = 3'h3,
    PS_16 = 3'h4
  } pixel_size_type;
endpackage : engine_regs_pkg

// File: inc/state_port_if.sv
// Purpose: carries the state-data memory access between the bank and its store
// Assumes: one access per cycle
// Notes:   word addressed, byte lane enables
`timescale 1ns/100ps
interface state_port_if #(parameter int AW = 6);
  logic          wr_en;
  logic [3:0]    byte_en;
  logic [AW-1:0] addr;
  logic [31:0]   wr_data;
  logic [31:0]   rd_data;
  modport owner (output wr_en, output byte_en, output addr, output wr_data, input rd_data);
  modport store (input wr_en, input byte_en, input addr, input wr_data, output rd_data);
endinterface : state_port_if

// File: rtl/state_store.sv
// Purpose: holds the saved engine state words for parts A and B
// Assumes: single clock, synchronous reset not applied to contents
// Notes:   read data comes out of a register
`timescale 1ns/100ps
`include "engine_regs_consts.svh"
module state_store #(
  parameter int AW = 6
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // access port
  state_port_if.store port
);
  // one store per byte lane, so every lane is written by one process only
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      logic [7:0] lane_mem [0:(1<<AW)-1];
      logic [7:0] lane_rd_reg;
      always_ff @(posedge clk_i) begin
        if (port.wr_en && port.byte_en[g]) begin
          lane_mem[port.addr] <= port.wr_data[8*g +: 8];
        end
      end
      // registered read of this lane
      always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
          lane_rd_reg <= `RST_BYTE;
        end else begin
          lane_rd_reg <= lane_mem[port.addr];
        end
      end
    end
  endgenerate
  assign port.rd_data = {g_lane[3].lane_rd_reg, g_lane[2].lane_rd_reg,
                         g_lane[1].lane_rd_reg, g_lane[0].lane_rd_reg};
endmodule : state_store

// File: rtl/engine_regs.sv
// Purpose: control/status, state save-restore ports and banked map descriptors
// Assumes: byte-wide register port; state ports at their own selects with lane enables
// Notes:   datapath is outside; it reports op_done and takes the descriptors
`timescale 1ns/100ps
`include "engine_regs_consts.svh"
module engine_regs
  import engine_regs_pkg::*;
#(
  parameter int AW = 6,
  parameter bit WIDE_PIXEL = 1'b1
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // byte register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  // alternate byte order for the word registers
  input  wire logic        alt_order_i,
  // state data ports, part select 0 = A, 1 = B
  input  wire logic        sd_wr_i,
  input  wire logic        sd_rd_i,
  input  wire logic        sd_part_i,
  input  wire logic [3:0]  sd_be_i,
  input  wire logic [31:0] sd_wdata_i,
  output logic      [31:0] sd_rdata_o,
  output logic             sd_valid_o,
  // datapath side
  input  wire logic        op_start_i,
  input  wire logic        op_done_i,
  output logic             engine_busy_o,
  output logic             halt_o,
  output logic             reset_engine_o,
  output logic             tlb_flush_o,
  output logic      [31:0] map_base_o    [4],
  output logic      [15:0] map_width_o   [4],
  output logic      [15:0] map_height_o  [4],
  output logic      [7:0]  map_format_o  [4]
);
  // ==================================================
  // state machine and control
  engine_state_type state_reg, state_next;
  logic        suspend_reg;
  logic        save_sel_reg;
  logic        terminate_reg;
  logic [3:0]  term_cnt_reg;
  logic [1:0]  map_bank_index_reg;
  logic [AW-2:0] sd_cnt_reg [2];
  logic        sd_rd_pend_reg;
  logic [3:0]  be_swap;
  logic [31:0] wdata_lane;
  logic        engine_busy;

  assign engine_busy = (state_reg != ST_IDLE);
  assign engine_busy_o = engine_busy;
  assign halt_o = (state_reg == ST_SUSPENDED);
  assign reset_engine_o = (state_reg == ST_TERMINATE) && (term_cnt_reg == `TERM_CYCLES);

  // next state of the run sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (terminate_reg) state_next = ST_TERMINATE;
        else if (op_start_i) state_next = ST_RUN;
      end
      ST_RUN: begin
        if (terminate_reg) state_next = ST_TERMINATE;
        else if (suspend_reg) state_next = ST_SUSPENDED;
        else if (op_done_i) state_next = ST_IDLE;
      end
      ST_SUSPENDED: begin
        if (terminate_reg) state_next = ST_TERMINATE;
        else if (!suspend_reg) state_next = ST_RUN;
      end
      ST_TERMINATE: begin
        if (term_cnt_reg == `TERM_CYCLES) state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  // termination timer; it lets the datapath drain before the reset pulse
  always_ff @(posedge clk_i) begin
    if (!resetn_i || state_reg != ST_TERMINATE) term_cnt_reg <= 4'h0;
    else term_cnt_reg <= term_cnt_reg + 4'h1;
  end

  logic ctl_wr;
  assign ctl_wr = reg_wr_i && (reg_addr_i == `OFF_CONTROL);

  // control bits; terminate completion clears suspend and save select, and terminate unless it is written again in that cycle
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      suspend_reg   <= 1'b0;
      save_sel_reg  <= 1'b0;
      terminate_reg <= 1'b0;
    end else if (reset_engine_o) begin
      suspend_reg   <= 1'b0;
      save_sel_reg  <= 1'b0;
      // a fresh terminate request in the clearing cycle wins, so it is not lost
      terminate_reg <= ctl_wr && reg_wdata_i[`BIT_TERMINATE];
    end else if (ctl_wr) begin
      suspend_reg   <= reg_wdata_i[`BIT_SUSPEND];
      save_sel_reg  <= reg_wdata_i[`BIT_SAVE_SEL];
      terminate_reg <= terminate_reg | reg_wdata_i[`BIT_TERMINATE];
    end
  end

  // flush pulse on entry to suspension
  always_ff @(posedge clk_i) begin
    if (!resetn_i) tlb_flush_o <= 1'b0;
    else tlb_flush_o <= (state_next == ST_SUSPENDED) && (state_reg != ST_SUSPENDED);
  end

  // ==================================================
  // descriptor banks
  always_ff @(posedge clk_i) begin
    if (!resetn_i) map_bank_index_reg <= `BANK_MASK_MAP;
    else if (reg_wr_i && reg_addr_i == `OFF_BANK_SELECT) begin
      map_bank_index_reg <= reg_wdata_i[1:0];
    end
  end

  // only the indexed bank takes writes
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_bank
      logic sel;
      logic [1:0] lane_off;
      assign sel = (map_bank_index_reg == 2'(b)) && reg_wr_i;
      // alternate order flips the byte position within the word
      assign lane_off = alt_order_i ? ~reg_addr_i[1:0] : reg_addr_i[1:0];
      always_ff @(posedge clk_i) begin
        if (!resetn_i || reset_engine_o) begin
          map_base_o[b]   <= `RST_WORD;
          map_width_o[b]  <= `RST_HALF;
          map_height_o[b] <= `RST_HALF;
          map_format_o[b] <= `RST_BYTE;
        end else if (sel) begin
          if (reg_addr_i[7:2] == `OFF_BASE >> 2) begin
            map_base_o[b][8*lane_off +: 8] <= reg_wdata_i;
          end else if (reg_addr_i[7:2] == `OFF_WIDTH >> 2) begin
            // width low half, height high half; used by steps, wrap and scissor
            if (lane_off[1] == 1'b0) map_width_o[b][8*lane_off[0] +: 8] <= reg_wdata_i;
            else map_height_o[b][8*lane_off[0] +: 8] <= reg_wdata_i;
          end else if (reg_addr_i == `OFF_FORMAT) begin
            if (b == 0) begin
              // mask map: only the order bit is kept, size fixed at one bit
              map_format_o[b] <= reg_wdata_i & `FMT_ORDER_MASK;
            end else if (reg_wdata_i[`FMT_SIZE_MSB:0] == `SIZE_16 && !WIDE_PIXEL) begin
              map_format_o[b] <= map_format_o[b];
            end else begin
              map_format_o[b] <= reg_wdata_i & `FMT_VALID_MASK;
            end
          end
        end
      end
    end
  endgenerate

  // ==================================================
  // state data ports with per-part sequential counters
  state_port_if #(.AW(AW)) sp ();
  state_store #(.AW(AW)) u_store (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .port     (sp.store)
  );

  // port access only while suspended, in the selected direction
  logic sd_ok_wr, sd_ok_rd;
  assign sd_ok_wr = sd_wr_i && halt_o && !save_sel_reg;
  assign sd_ok_rd = sd_rd_i && halt_o && save_sel_reg;
  assign be_swap = sd_be_i;
  assign wdata_lane = sd_wdata_i;
  assign sp.wr_en = sd_ok_wr;
  assign sp.byte_en = be_swap;
  assign sp.addr = {sd_part_i, sd_cnt_reg[sd_part_i]};
  assign sp.wr_data = wdata_lane;

  // the counter steps on an access that enables lane 3, so mixed widths work
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_part
      always_ff @(posedge clk_i) begin
        if (!resetn_i || reset_engine_o || (ctl_wr && reg_wdata_i[`BIT_SUSPEND])) begin
          sd_cnt_reg[p] <= '0;
        end else if ((sd_ok_wr || sd_ok_rd) && sd_part_i == 1'(p) && sd_be_i[3]) begin
          sd_cnt_reg[p] <= sd_cnt_reg[p] + 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!resetn_i) sd_rd_pend_reg <= 1'b0;
    else sd_rd_pend_reg <= sd_ok_rd;
  end
  assign sd_valid_o = sd_rd_pend_reg;
  assign sd_rdata_o = sp.rd_data;

  // ==================================================
  // register read data
  always_ff @(posedge clk_i) begin
    if (!resetn_i) reg_rdata_o <= `RST_BYTE;
    else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `OFF_AUX_STATUS: reg_rdata_o <= {engine_busy, 7'h00};
        `OFF_LEN_A:      reg_rdata_o <= `LEN_A_WORDS;
        `OFF_LEN_B:      reg_rdata_o <= `LEN_B_WORDS;
        `OFF_CONTROL: begin
          reg_rdata_o <= {engine_busy, 1'b0, terminate_reg, halt_o,
                          suspend_reg, 1'b0, save_sel_reg, 1'b0};
        end
        default:         reg_rdata_o <= `RST_BYTE;
      endcase
    end
  end

  // ==================================================
  // checks
  a_busy_bits: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reg_rd_i && reg_addr_i == `OFF_CONTROL |=> reg_rdata_o[7] == $past(engine_busy))
    else $error("busy bit mismatch");
  a_aux_busy: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reg_rd_i && reg_addr_i == `OFF_AUX_STATUS |=> reg_rdata_o == {$past(engine_busy), 7'h00})
    else $error("aux busy mismatch");
  a_term_clears: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(terminate_reg) |-> ##[1:6] reset_engine_o)
    else $error("terminate did not complete");
  a_term_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reset_engine_o |=> state_reg == ST_IDLE && !suspend_reg
      && terminate_reg == $past(ctl_wr && reg_wdata_i[`BIT_TERMINATE]))
    else $error("not reset after terminate");
  a_suspend_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_reg == ST_RUN && suspend_reg && !terminate_reg |=> halt_o)
    else $error("suspend not reported");
  a_restart_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
    halt_o && !suspend_reg && !terminate_reg |=> !halt_o)
    else $error("restart kept flag");
  a_flush_suspend: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(halt_o) |-> tlb_flush_o)
    else $error("no flush on suspend");
  a_port_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    sp.wr_en |-> halt_o && !save_sel_reg)
    else $error("restore write outside restore");
  a_save_no_step: assert property (@(posedge clk_i) disable iff (!resetn_i)
    sd_wr_i && !sd_rd_i && save_sel_reg && !ctl_wr && !reset_engine_o
    |=> $stable(sd_cnt_reg[0]) && $stable(sd_cnt_reg[1]))
    else $error("write stepped a save counter");
  a_bank_only: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reg_wr_i && reg_addr_i == `OFF_FORMAT && map_bank_index_reg == 2'h1 && !reset_engine_o
    |=> map_format_o[2] == $past(map_format_o[2]))
    else $error("unselected bank changed");
endmodule : engine_regs

// File: testbench/engine_regs_tb.sv
// Purpose: self-checking bench for the engine register bank
// Assumes: byte register port, one-cycle strobes, sync active-low reset
// Notes:   scenarios are tasks; each judges its own results before returning
`timescale 1ns/100ps
`include "engine_regs_consts.svh"
module engine_regs_tb;
  import engine_regs_pkg::*;
  // ==================================================
  // signals
  logic        clk_i, resetn_i, reg_wr_i, reg_rd_i, alt_order_i;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic        sd_wr_i, sd_rd_i, sd_part_i, sd_valid_o;
  logic [3:0]  sd_be_i;
  logic [31:0] sd_wdata_i, sd_rdata_o;
  logic        op_start_i, op_done_i, engine_busy_o, halt_o, reset_engine_o, tlb_flush_o;
  logic [31:0] map_base   [4];
  logic [15:0] map_width  [4];
  logic [15:0] map_height [4];
  logic [7:0]  map_format [4];
  int          n_fail, n_checks, n_flush, n_reset;
  logic [7:0]  d;
  engine_regs dut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .alt_order_i(alt_order_i), .sd_wr_i(sd_wr_i),
    .sd_rd_i(sd_rd_i), .sd_part_i(sd_part_i), .sd_be_i(sd_be_i), .sd_wdata_i(sd_wdata_i),
    .sd_rdata_o(sd_rdata_o), .sd_valid_o(sd_valid_o), .op_start_i(op_start_i),
    .op_done_i(op_done_i), .engine_busy_o(engine_busy_o), .halt_o(halt_o),
    .reset_engine_o(reset_engine_o), .tlb_flush_o(tlb_flush_o), .map_base_o(map_base),
    .map_width_o(map_width), .map_height_o(map_height), .map_format_o(map_format));
  // ==================================================
  // clock, pulse counters, watchdog
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // pulses last one cycle, so count them rather than sample them late
  always @(negedge clk_i) begin
    if (tlb_flush_o === 1'b1) n_flush++;
    if (reset_engine_o === 1'b1) n_reset++;
  end
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
  // ==================================================
  // bus tasks and compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i); #1;
    reg_wr_i = 1'b1; reg_addr_i = a; reg_wdata_i = v;
    @(posedge clk_i); #1;
    reg_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i); #1;
    reg_rd_i = 1'b1; reg_addr_i = a;
    @(posedge clk_i); #1;
    reg_rd_i = 1'b0;
    v = reg_rdata_o;
  endtask : rd
  task automatic pulse(input bit done);
    @(posedge clk_i); #1;
    if (done) op_done_i = 1'b1; else op_start_i = 1'b1;
    @(posedge clk_i); #1;
    op_done_i = 1'b0; op_start_i = 1'b0;
  endtask : pulse
  task automatic sdw(input logic part, input logic [3:0] be, input logic [31:0] v);
    @(posedge clk_i); #1;
    sd_wr_i = 1'b1; sd_part_i = part; sd_be_i = be; sd_wdata_i = v;
    @(posedge clk_i); #1;
    sd_wr_i = 1'b0;
  endtask : sdw
  // read one word; valid must equal vexp, and data must match when vexp is set, the cycle after the strobe
  task automatic sdr(input logic part, input logic vexp, input logic [31:0] v);
    @(posedge clk_i); #1;
    sd_rd_i = 1'b1; sd_part_i = part; sd_be_i = 4'hf;
    @(posedge clk_i); #1;
    sd_rd_i = 1'b0;
    chk(32'(sd_valid_o), 32'(vexp));
    if (vexp) chk(sd_rdata_o, v);
  endtask : sdr
  // ==================================================
  // scenarios
  task automatic t_status;
    rd(`OFF_CONTROL, d); chk(32'(d), 32'h0);
    rd(`OFF_AUX_STATUS, d); chk(32'(d[7]), 32'h0);
    wr(`OFF_LEN_A, 8'h55);
    rd(`OFF_LEN_A, d); chk(32'(d), 32'(`LEN_A_WORDS));
    rd(`OFF_LEN_B, d); chk(32'(d), 32'(`LEN_B_WORDS));
    rd(8'h40, d); chk(32'(d), 32'h0);
    sdr(1'b0, 1'b0, 32'h0);
  endtask : t_status
  task automatic t_banks;
    logic [31:0] keep;
    for (int i = 0; i < 4; i++) begin
      wr(`OFF_BANK_SELECT, 8'(i));
      for (int k = 0; k < 4; k++) wr(8'(`OFF_BASE + k), 8'(i * 16 + k));
      wr(`OFF_WIDTH, 8'(100 + i)); wr(8'h19, 8'h0f);
      wr(`OFF_HEIGHT, 8'(200 + i)); wr(8'h1b, 8'h02);
      wr(`OFF_FORMAT, 8'h0b);
    end
    // second pass so a write landing in the wrong bank shows up
    for (int i = 0; i < 4; i++) begin
      chk(map_base[i], {8'(i*16+3), 8'(i*16+2), 8'(i*16+1), 8'(i*16)});
      chk(32'(map_width[i]), 32'({8'h0f, 8'(100 + i)}));
      chk(32'(map_height[i]), 32'({8'h02, 8'(200 + i)}));
      chk(32'(map_format[i]), (i == 0) ? 32'h08 : 32'h0b);
    end
    // pattern source kept one bit deep; wide pixels on another map
    wr(`OFF_BANK_SELECT, 8'h03);
    wr(`OFF_FORMAT, 8'h00);
    wr(`OFF_BANK_SELECT, 8'h01);
    wr(`OFF_FORMAT, 8'h0c);
    @(posedge clk_i); #1;
    chk(32'(map_format[3]), 32'h00);
    chk(32'(map_format[1]), 32'h0c);
    keep = map_base[2];
    wr(`OFF_BANK_SELECT, 8'h02);
    alt_order_i = 1'b1;
    wr(`OFF_BASE, 8'h5a);
    alt_order_i = 1'b0;
    @(posedge clk_i); #1;
    chk(map_base[2], {8'h5a, keep[23:0]});
  endtask : t_banks
  task automatic t_terminate;
    pulse(1'b0);
    chk(32'(engine_busy_o), 32'h1);
    rd(`OFF_AUX_STATUS, d); chk(32'(d[7]), 32'h1);
    rd(`OFF_CONTROL, d); chk(32'(d[7]), 32'h1);
    wr(`OFF_CONTROL, 8'h20);
    // poll busy as software would, bounded
    for (int n = 0; n < 20 && d[7] !== 1'b0; n++) rd(`OFF_CONTROL, d);
    chk(32'(d), 32'h0);
    chk(32'(n_reset), 32'h1);
    chk(map_base[1], 32'h0);
  endtask : t_terminate
  task automatic t_suspend;
    pulse(1'b0);
    wr(`OFF_CONTROL, 8'h0a);
    d = 8'h00;
    for (int n = 0; n < 20 && d[4] !== 1'b1; n++) rd(`OFF_CONTROL, d);
    chk(32'(d[4]), 32'h1);
    chk(32'(halt_o), 32'h1);
    chk(32'(n_flush), 32'h1);
    // restore direction, first word in two halves
    wr(`OFF_CONTROL, 8'h08);
    sdw(1'b0, 4'h3, 32'h0000_a5a5);
    sdw(1'b0, 4'hc, 32'h5a5a_0000);
    for (int i = 1; i < `LEN_A_WORDS; i++) sdw(1'b0, 4'hf, 32'h1000_0000 + i * 32'h0101);
    for (int i = 0; i < `LEN_B_WORDS; i++) sdw(1'b1, 4'hf, 32'h2000_0000 + i);
    // save direction rewinds; a write now must be ignored
    wr(`OFF_CONTROL, 8'h0a);
    sdw(1'b0, 4'hf, 32'hdead_beef);
    sdr(1'b0, 1'b1, 32'h5a5a_a5a5);
    for (int i = 1; i < `LEN_A_WORDS; i++) sdr(1'b0, 1'b1, 32'h1000_0000 + i * 32'h0101);
    for (int i = 0; i < `LEN_B_WORDS; i++) sdr(1'b1, 1'b1, 32'h2000_0000 + i);
    wr(`OFF_CONTROL, 8'h00);
    rd(`OFF_CONTROL, d);
    chk(32'(d[4]), 32'h0);
    chk(32'(halt_o), 32'h0);
    chk(32'(d[7]), 32'h1);
    pulse(1'b1);
    rd(`OFF_AUX_STATUS, d); chk(32'(d[7]), 32'h0);
    // a second suspension is cleared by terminate before the next start
    pulse(1'b0);
    wr(`OFF_CONTROL, 8'h08);
    wr(`OFF_CONTROL, 8'h20);
    d = 8'hff;
    for (int n = 0; n < 20 && d[7] !== 1'b0; n++) rd(`OFF_CONTROL, d);
    chk(32'(d), 32'h0);
    chk(32'(n_flush), 32'h2);
    chk(32'(n_reset), 32'h2);
    pulse(1'b0);
    chk(32'(engine_busy_o), 32'h1);
    pulse(1'b1);
  endtask : t_suspend
  // ==================================================
  // verdict
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial begin
    {reg_wr_i, reg_rd_i, alt_order_i, sd_wr_i, sd_rd_i, sd_part_i} = '0;
    {op_start_i, op_done_i, reg_addr_i, reg_wdata_i, sd_be_i, sd_wdata_i} = '0;
    {n_fail, n_checks, n_flush, n_reset} = '0;
    resetn_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    t_status();
    t_banks();
    t_terminate();
    t_suspend();
    finish_test();
  end
endmodule : engine_regs_tb
